// ---- dqm_pkg.sv ----
// package: addresses, layouts and reset values of the reference, invert and bank mask slice
package dqm_pkg;
    localparam logic [5:0] DQM_MA_VREF_DQ = 6'h0E;
    localparam logic [5:0] DQM_MA_INVERT = 6'h0F;
    localparam logic [5:0] DQM_MA_BANK_MASK = 6'h10;
    localparam int DQM_RANGE_BIT = 6;
    localparam int DQM_CODE_MSB = 5;
    localparam logic [5:0] DQM_VREF_CODE_MAX = 6'h32;
    localparam logic [5:0] DQM_VREF_CODE_RESET = 6'h1D;
    localparam logic DQM_VREF_RANGE_RESET = 1'b1;
    localparam logic [7:0] DQM_INVERT_RESET = 8'h55;
    localparam logic [7:0] DQM_BANK_MASK_RESET = 8'h00;
    localparam int DQM_NUM_SET_POINTS = 2;
    localparam int DQM_NUM_CHANNELS = 2;
    localparam int DQM_NUM_BANKS = 8;
    localparam int DQM_NUM_LANES = 8;

    typedef struct packed {
        logic range_sel;
        logic [5:0] code;
    } dqm_vref_s;

    typedef struct packed {
        logic write;
        logic read;
        logic [5:0] addr;
        logic [7:0] op;
    } dqm_cmd_s;

    localparam dqm_vref_s DQM_VREF_RESET = '{range_sel: DQM_VREF_RANGE_RESET, code: DQM_VREF_CODE_RESET};
endpackage

// ---- dqm_cal_lanes.sv ----
// lower byte calibration lanes: per-lane inversion of the pattern bit, mask lane kept true
`timescale 1ns/1ps
`default_nettype none
module dqm_cal_lanes
    import dqm_pkg::*;
(
    input wire logic pattern_bit,
    input wire logic [7:0] invert_mask,
    output logic [7:0] lane_bits,
    output logic mask_lane_bit
);
    genvar n;
    generate
        for (n = 0; n < DQM_NUM_LANES; n++) begin : g_lane
            // lane n follows invert bit n only
            assign lane_bits[n] = pattern_bit ^ invert_mask[n];
        end
    endgenerate

    // the mask/inversion lane never sees the invert register
    assign mask_lane_bit = pattern_bit;
endmodule
`default_nettype wire

// ---- dqm_mode_regs.sv ----
// mode register slice: reference code copies, lower byte invert mask, per-channel bank refresh mask
//
// Behaviour
// - reference code is six bits; only 000000 to 110010 valid, others reserved.
// - bit 6 of the reference register selects which reference range is used.
// - separate reference code and range kept for each of two set points.
// - invert register is eight bits, write only; a one inverts that lane's pattern.
// - invert bits 7 to 0 map onto lower byte lanes 7 to 0.
// - invert register resets to 55h, inverting lanes 0, 2, 4 and 6.
// - mask/inversion lane always carries the true pattern bit.
// - no data bus inversion during read calibration, even when enabled.
// - bank mask is eight bits, write only, bit n for bank n, resets to zero.
// - a set mask bit suppresses refresh of that bank.
// - each channel keeps its own bank refresh mask.
// - reference reads and writes touch only the copy chosen by write set point.
// - operation uses only the copy chosen by the operating set point.
// - reference read returns eight bits on lanes 7 to 0, reserved bits zero.
`timescale 1ns/1ps
`default_nettype none
module dqm_mode_regs
    import dqm_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic MRW_VALID,
    input wire logic MRR_VALID,
    input wire logic [5:0] MA,
    input wire logic [7:0] OP,
    input wire logic CHANNEL,
    input wire logic WRITE_SET_POINT,
    input wire logic OPERATING_SET_POINT,
    input wire logic DBI_READ_EN,
    input wire logic CAL_ACTIVE,
    input wire logic CAL_BIT,
    input wire logic REF_REQ,
    input wire logic REF_CHANNEL,
    input wire logic [2:0] REF_BANK,
    output logic RD_VALID,
    output logic [7:0] RD_DQ,
    output logic [5:0] VREF_CODE,
    output logic VREF_RANGE,
    output logic [7:0] CAL_DQ,
    output logic CAL_DMI,
    output logic DBI_ACTIVE,
    output logic REF_DO,
    output logic [7:0] BANK_MASK_CH0,
    output logic [7:0] BANK_MASK_CH1
);
    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] target);
        hit = (addr == target);
    endfunction

    dqm_cmd_s cmd;
    assign cmd = '{write: MRW_VALID, read: MRR_VALID, addr: MA, op: OP};

    dqm_vref_s vref_r [DQM_NUM_SET_POINTS];
    logic [7:0] invert_r;
    logic [7:0] bank_mask_r [DQM_NUM_CHANNELS];
    logic vref_wr;
    logic [7:0] lane_bits;
    logic mask_lane_bit;
    dqm_vref_s rd_copy;

    // reserved codes are dropped so the analog side never sees them
    assign vref_wr = cmd.write && hit(cmd.addr, DQM_MA_VREF_DQ)
                     && (cmd.op[DQM_CODE_MSB:0] <= DQM_VREF_CODE_MAX);
    assign rd_copy = vref_r[WRITE_SET_POINT];

    // ----------------------------------------------------------------
    // reference copies
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            vref_r[0] <= DQM_VREF_RESET;
            vref_r[1] <= DQM_VREF_RESET;
        end else if (vref_wr) begin
            // only the write set point copy changes
            vref_r[WRITE_SET_POINT] <= '{range_sel: cmd.op[DQM_RANGE_BIT],
                                         code: cmd.op[DQM_CODE_MSB:0]};
        end
    end

    // inactive copy may change freely; outputs follow the operating one
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            VREF_CODE <= DQM_VREF_CODE_RESET;
            VREF_RANGE <= DQM_VREF_RANGE_RESET;
        end else begin
            VREF_CODE <= vref_r[OPERATING_SET_POINT].code;
            VREF_RANGE <= vref_r[OPERATING_SET_POINT].range_sel;
        end
    end

    // ----------------------------------------------------------------
    // write-only registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            invert_r <= DQM_INVERT_RESET;
        end else if (cmd.write && hit(cmd.addr, DQM_MA_INVERT)) begin
            invert_r <= cmd.op;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bank_mask_r[0] <= DQM_BANK_MASK_RESET;
            bank_mask_r[1] <= DQM_BANK_MASK_RESET;
        end else if (cmd.write && hit(cmd.addr, DQM_MA_BANK_MASK)) begin
            bank_mask_r[CHANNEL] <= cmd.op;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BANK_MASK_CH0 <= DQM_BANK_MASK_RESET;
            BANK_MASK_CH1 <= DQM_BANK_MASK_RESET;
        end else begin
            BANK_MASK_CH0 <= bank_mask_r[0];
            BANK_MASK_CH1 <= bank_mask_r[1];
        end
    end

    // ----------------------------------------------------------------
    // refresh gating
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REF_DO <= 1'b0;
        end else begin
            REF_DO <= REF_REQ && !bank_mask_r[REF_CHANNEL][REF_BANK];
        end
    end

    // ----------------------------------------------------------------
    // mode register read
    // ----------------------------------------------------------------
    // write-only addresses read back as zero rather than leaking state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RD_VALID <= 1'b0;
            RD_DQ <= 8'h00;
        end else begin
            RD_VALID <= cmd.read;
            if (cmd.read && hit(cmd.addr, DQM_MA_VREF_DQ)) begin
                RD_DQ <= {1'b0, rd_copy.range_sel, rd_copy.code};
            end else begin
                RD_DQ <= 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // read calibration lanes
    // ----------------------------------------------------------------
    dqm_cal_lanes dqm_cal_lanes_inst (
        .pattern_bit(CAL_BIT),
        .invert_mask(invert_r),
        .lane_bits(lane_bits),
        .mask_lane_bit(mask_lane_bit)
    );

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            CAL_DQ <= 8'h00;
            CAL_DMI <= 1'b0;
            DBI_ACTIVE <= 1'b0;
        end else begin
            CAL_DQ <= CAL_ACTIVE ? lane_bits : 8'h00;
            CAL_DMI <= CAL_ACTIVE ? mask_lane_bit : 1'b0;
            DBI_ACTIVE <= DBI_READ_EN && !CAL_ACTIVE;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_vref_write: assert property (vref_wr |=> vref_r[$past(WRITE_SET_POINT)]
        == {$past(OP[DQM_RANGE_BIT]), $past(OP[DQM_CODE_MSB:0])})
        else $error("reference write lost");
    a_reserved_drop: assert property (MRW_VALID && hit(MA, DQM_MA_VREF_DQ)
        && OP[DQM_CODE_MSB:0] > DQM_VREF_CODE_MAX |=> $stable(vref_r[0]) && $stable(vref_r[1]))
        else $error("reserved reference code stored");
    a_other_copy: assert property (vref_wr |=> vref_r[!$past(WRITE_SET_POINT)]
        == $past(vref_r[!WRITE_SET_POINT]))
        else $error("inactive write copy disturbed");
    a_operating_copy: assert property (##1 {VREF_RANGE, VREF_CODE} == $past(vref_r[OPERATING_SET_POINT]))
        else $error("operating reference wrong copy");
    a_read_return: assert property (MRR_VALID && hit(MA, DQM_MA_VREF_DQ) |=> RD_VALID
        && RD_DQ == {1'b0, $past(rd_copy)})
        else $error("reference read data wrong");
    a_wo_read_zero: assert property (MRR_VALID && !hit(MA, DQM_MA_VREF_DQ) |=> RD_VALID && RD_DQ == 8'h00)
        else $error("write-only read not zero");
    a_lane_invert: assert property (CAL_ACTIVE |=> CAL_DQ == ({8{$past(CAL_BIT)}} ^ $past(invert_r)))
        else $error("calibration lane inversion wrong");
    a_mask_lane_true: assert property (CAL_ACTIVE |=> CAL_DMI == $past(CAL_BIT))
        else $error("mask lane inverted");
    a_no_dbi_cal: assert property (CAL_ACTIVE |=> !DBI_ACTIVE)
        else $error("inversion active during calibration");
    a_masked_bank: assert property (REF_REQ && bank_mask_r[REF_CHANNEL][REF_BANK] |=> !REF_DO)
        else $error("masked bank refreshed");
    a_unmasked_bank: assert property (REF_REQ && !bank_mask_r[REF_CHANNEL][REF_BANK] |=> REF_DO)
        else $error("unmasked bank not refreshed");
    a_invert_write: assert property (MRW_VALID && hit(MA, DQM_MA_INVERT) |=> invert_r == $past(OP))
        else $error("invert register write lost");
    a_bank_write: assert property (MRW_VALID && hit(MA, DQM_MA_BANK_MASK) |=> bank_mask_r[$past(CHANNEL)] == $past(OP))
        else $error("bank mask write lost");
    a_bank_other: assert property (MRW_VALID && hit(MA, DQM_MA_BANK_MASK) |=> bank_mask_r[!$past(CHANNEL)] == $past(bank_mask_r[!CHANNEL]))
        else $error("other channel mask disturbed");
    a_cal_idle: assert property (!CAL_ACTIVE |=> CAL_DQ == 8'h00 && !CAL_DMI)
        else $error("calibration lanes driven while idle");

    c_fsp1_write: cover property (vref_wr && WRITE_SET_POINT ##1 OPERATING_SET_POINT);
    c_ref_read: cover property (MRR_VALID && hit(MA, DQM_MA_VREF_DQ));
    c_cal_burst: cover property (CAL_ACTIVE [*4]);
    c_ch_diff: cover property (bank_mask_r[0] != bank_mask_r[1]);
    c_reserved_drop: cover property (MRW_VALID && hit(MA, DQM_MA_VREF_DQ) && OP[DQM_CODE_MSB:0] > DQM_VREF_CODE_MAX);
endmodule
`default_nettype wire

// ---- dqm_ctrl_model.sv ----
// controller model issuing mode register writes and reads
`timescale 1ns/1ps
`default_nettype none
module dqm_ctrl_model
    import dqm_pkg::*;
(
    input wire logic CLK,
    input wire logic RD_VALID,
    input wire logic [7:0] RD_DQ,
    output logic MRW_VALID,
    output logic MRR_VALID,
    output logic [5:0] MA,
    output logic [7:0] OP,
    output logic CHANNEL,
    output logic WRITE_SET_POINT
);
    initial begin
        MRW_VALID = 1'b0;
        MRR_VALID = 1'b0;
        MA = 6'h00;
        OP = 8'h00;
        CHANNEL = 1'b0;
        WRITE_SET_POINT = 1'b0;
    end
    // one strobe cycle; the answer is taken just after the edge that follows
    task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic ch,
        input logic sp, output logic [8:0] rd);
        @(posedge CLK);
        #1;
        MRW_VALID = wr;
        MRR_VALID = !wr;
        MA = a;
        OP = wr ? d : ~d;
        CHANNEL = ch;
        WRITE_SET_POINT = sp;
        @(posedge CLK);
        #1;
        rd = {RD_VALID, RD_DQ};
        MRW_VALID = 1'b0;
        MRR_VALID = 1'b0;
        // released qualifiers must not keep showing the last command
        MA = ~a;
        OP = ~OP;
    endtask
endmodule
`default_nettype wire

// ---- dq_vref_invert_bank_mask_regs_test.sv ----
// self-checking bench for the reference, invert and bank mask slice
`timescale 1ns/1ps
`default_nettype none
module dq_vref_invert_bank_mask_regs_test
    import dqm_pkg::*;
;
    logic CLK = 1'b0, RST = 1'b1, OPERATING_SET_POINT = 1'b0, DBI_READ_EN = 1'b0, CAL_ACTIVE = 1'b0;
    logic CAL_BIT = 1'b0, REF_REQ = 1'b0, REF_CHANNEL = 1'b0;
    logic [2:0] REF_BANK = 3'h0;
    logic MRW_VALID, MRR_VALID, CHANNEL, WRITE_SET_POINT, RD_VALID, VREF_RANGE, CAL_DMI, DBI_ACTIVE, REF_DO;
    logic [5:0] MA, VREF_CODE;
    logic [7:0] OP, RD_DQ, CAL_DQ, BANK_MASK_CH0, BANK_MASK_CH1, inv;
    logic [8:0] rd;
    logic [7:0] m [2];
    logic [6:0] v [2];
    int error_cnt = 0, n_compared = 0, cyc = 0;
    always #5 CLK = ~CLK;
    dqm_mode_regs dqm_mode_regs_inst (.CLK(CLK), .RST(RST), .MRW_VALID(MRW_VALID), .MRR_VALID(MRR_VALID),
        .MA(MA), .OP(OP), .CHANNEL(CHANNEL), .WRITE_SET_POINT(WRITE_SET_POINT),
        .OPERATING_SET_POINT(OPERATING_SET_POINT), .DBI_READ_EN(DBI_READ_EN), .CAL_ACTIVE(CAL_ACTIVE),
        .CAL_BIT(CAL_BIT), .REF_REQ(REF_REQ), .REF_CHANNEL(REF_CHANNEL), .REF_BANK(REF_BANK),
        .RD_VALID(RD_VALID), .RD_DQ(RD_DQ), .VREF_CODE(VREF_CODE), .VREF_RANGE(VREF_RANGE), .CAL_DQ(CAL_DQ),
        .CAL_DMI(CAL_DMI), .DBI_ACTIVE(DBI_ACTIVE), .REF_DO(REF_DO), .BANK_MASK_CH0(BANK_MASK_CH0),
        .BANK_MASK_CH1(BANK_MASK_CH1));
    dqm_ctrl_model dqm_ctrl_model_inst (.CLK(CLK), .RD_VALID(RD_VALID), .RD_DQ(RD_DQ), .MRW_VALID(MRW_VALID),
        .MRR_VALID(MRR_VALID), .MA(MA), .OP(OP), .CHANNEL(CHANNEL), .WRITE_SET_POINT(WRITE_SET_POINT));
    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge CLK);
        #1;
    endtask
    function automatic logic [7:0] cal_exp(input logic b, input logic [7:0] iv);
        return {8{b}} ^ iv;
    endfunction
    function automatic logic [8:0] rd_exp(input logic [6:0] r);
        return {2'b10, r};
    endfunction
    // the whole run needs well under a thousand cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(28));
        repeat (12) @(posedge CLK);
        #1;
        RST = 1'b0;
        chk("vref", {2'b00, VREF_RANGE, VREF_CODE}, {2'b00, DQM_VREF_RESET});
        chk("mask0", BANK_MASK_CH0, DQM_BANK_MASK_RESET);
        chk("mask1", BANK_MASK_CH1, DQM_BANK_MASK_RESET);
        dqm_ctrl_model_inst.cmd(1'b0, DQM_MA_VREF_DQ, 8'h00, 1'b0, 1'b0, rd);
        chk("rd vref", rd, rd_exp(DQM_VREF_RESET));
        tick();
        chk("rd idle", {RD_VALID, RD_DQ}, 9'h000);
        dqm_ctrl_model_inst.cmd(1'b0, DQM_MA_INVERT, 8'h00, 1'b0, 1'b0, rd);
        chk("rd invert", rd, 9'h100);
        CAL_ACTIVE = 1'b1;
        CAL_BIT = 1'b1;
        DBI_READ_EN = 1'b1;
        tick();
        chk("cal dq", CAL_DQ, cal_exp(1'b1, DQM_INVERT_RESET));
        chk("dmi", CAL_DMI, 1'b1);
        chk("dbi", DBI_ACTIVE, 1'b0);
        CAL_ACTIVE = 1'b0;
        tick();
        chk("dbi", DBI_ACTIVE, 1'b1);
        chk("cal idle", {CAL_DMI, CAL_DQ}, 9'h000);
        $display("test reset done");
        CAL_ACTIVE = 1'b1;
        for (int i = 0; i < 24; i++) begin
            inv = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            dqm_ctrl_model_inst.cmd(1'b1, DQM_MA_INVERT, inv, 1'b0, 1'b0, rd);
            CAL_BIT = 1'($urandom);
            tick();
            chk("cal dq", CAL_DQ, cal_exp(CAL_BIT, inv));
            chk("dmi", CAL_DMI, CAL_BIT);
        end
        $display("test invert done");
        v[0] = {1'b0, DQM_VREF_CODE_MAX};
        v[1] = {1'($urandom), 6'($urandom_range(DQM_VREF_CODE_MAX))};
        for (int s = 0; s < 2; s++) begin
            dqm_ctrl_model_inst.cmd(1'b1, DQM_MA_VREF_DQ, {1'b0, v[s]}, 1'b0, 1'(s), rd);
            tick();
            chk("vref", {2'b00, VREF_RANGE, VREF_CODE}, {2'b00, v[0]});
        end
        for (int s = 0; s < 2; s++) begin
            OPERATING_SET_POINT = 1'(s);
            dqm_ctrl_model_inst.cmd(1'b0, DQM_MA_VREF_DQ, 8'h00, 1'b0, 1'(s), rd);
            chk("rd vref", rd, rd_exp(v[s]));
            chk("vref", {2'b00, VREF_RANGE, VREF_CODE}, {2'b00, v[s]});
            dqm_ctrl_model_inst.cmd(1'b1, DQM_MA_VREF_DQ, 8'($urandom_range(6'h3F, DQM_VREF_CODE_MAX + 1)),
                1'b0, 1'(s), rd);
            tick();
            chk("reserved", {2'b00, VREF_RANGE, VREF_CODE}, {2'b00, v[s]});
        end
        $display("test reference done");
        m[0] = 8'($urandom);
        m[1] = ~m[0];
        for (int c = 0; c < 2; c++) begin
            dqm_ctrl_model_inst.cmd(1'b1, DQM_MA_BANK_MASK, m[c], 1'(c), 1'b0, rd);
        end
        tick();
        chk("mask0", BANK_MASK_CH0, m[0]);
        chk("mask1", BANK_MASK_CH1, m[1]);
        dqm_ctrl_model_inst.cmd(1'b0, DQM_MA_BANK_MASK, 8'h00, 1'b0, 1'b0, rd);
        chk("rd mask", rd, 9'h100);
        REF_REQ = 1'b1;
        for (int k = 0; k < 16; k++) begin
            REF_CHANNEL = 1'(k / 8);
            REF_BANK = 3'(k);
            tick();
            chk("refresh", REF_DO, !m[k / 8][k % 8]);
        end
        REF_REQ = 1'b0;
        tick();
        chk("no refresh", REF_DO, 1'b0);
        $display("test refresh done");
        // reset in mid-run must throw away everything written so far
        RST = 1'b1;
        tick();
        chk("vref", {2'b00, VREF_RANGE, VREF_CODE}, {2'b00, DQM_VREF_RESET});
        chk("mask0", BANK_MASK_CH0, DQM_BANK_MASK_RESET);
        chk("mask1", BANK_MASK_CH1, DQM_BANK_MASK_RESET);
        RST = 1'b0;
        CAL_ACTIVE = 1'b1;
        CAL_BIT = 1'b0;
        tick();
        chk("cal dq", CAL_DQ, cal_exp(1'b0, DQM_INVERT_RESET));
        CAL_ACTIVE = 1'b0;
        $display("test mid reset done");
        stop_test();
    end
endmodule
`default_nettype wire
